// >>> hw/dip_pkg.sv
// Package with constants and carrier types for the dual interrupt priority and stop wake-up block.
// Functional notes
// - Primary controller outranks secondary controller at equal level and priority.
// - Equal level and priority: primary served first.
// - Higher secondary level, or equal level and higher priority, wins.
// - Eight-bit low-power control register, software-written.
// - Wake evaluation only while stop wake enabled.
// - Compared wake mask clamped to 0..6.
// - Stopped core enables purely combinational wake path.
// - Wake when active level exceeds mask.
// - Merged wake goes to clock generator.
// - Soft ack returns best vector across controllers.
// - No active source: zero vector, clear level-priority.
package dip_pkg;

    // Number of interrupt sources feeding each controller.
    localparam int unsigned NSRC = 8;
    // Width of a source index.
    localparam int unsigned IDXW = 3;

    // Low-power control register layout: enable bit and mask level field.
    localparam int unsigned LPC_EN_BIT  = 7;
    localparam int unsigned LPC_MASK_HI = 6;
    localparam int unsigned LPC_MASK_LO = 4;
    localparam logic [7:0]  LPC_RESET   = 8'h00;

    // Highest mask the comparator may see, so a top-level request always wakes.
    localparam logic [2:0] MASK_CEIL = 3'h6;
    // Highest interrupt level.
    localparam logic [2:0] LEVEL_TOP = 3'h7;

    // Vector bases of the two controllers; the source index is added to them.
    localparam logic [7:0] PRI_VEC_BASE = 8'h40;
    localparam logic [7:0] SEC_VEC_BASE = 8'h80;
    // Vector returned when nothing is pending.
    localparam logic [7:0] VEC_NONE     = 8'h00;
    // Cleared level and priority value.
    localparam logic [5:0] LP_NONE      = 6'h00;

    // One incoming interrupt source.
    typedef struct packed {
        logic       active;
        logic [2:0] level;
        logic [2:0] prio;
    } dip_src_t;

    // Best pending request of one controller.
    typedef struct packed {
        logic            valid;
        logic [2:0]      level;
        logic [2:0]      prio;
        logic [IDXW-1:0] idx;
    } dip_best_t;

endpackage

// >>> hw/dip_ctrl_eval.sv
// One controller's combinational request ranking and stop wake-up evaluation.
module dip_ctrl_eval (
    input  dip_pkg::dip_src_t  [dip_pkg::NSRC-1:0] i_src,
    input  wire logic          [2:0]               i_mask,
    input  wire logic                              i_wake_en,
    output dip_pkg::dip_best_t                     o_best,
    output logic                                   o_wake
);

    // Per-source wake terms, each a pure gate of the source and the mask.
    logic [dip_pkg::NSRC-1:0] src_wake;

    // A source asks for wake-up when active and above the clamped mask.
    for (genvar g = 0; g < dip_pkg::NSRC; g++) begin : g_wake
        assign src_wake[g] = i_src[g].active && (i_src[g].level > i_mask);
    end

    // Wake path holds no storage at all, only gates.
    assign o_wake = i_wake_en && (|src_wake);

    // Scan the sources; lower index keeps ties, higher level then priority wins.
    always_comb begin
        o_best = '0;
        for (int i = 0; i < dip_pkg::NSRC; i++) begin
            if (i_src[i].active && (!o_best.valid || {i_src[i].level, i_src[i].prio} >
                                    {o_best.level, o_best.prio})) begin
                o_best.valid = 1'b1;
                o_best.level = i_src[i].level;
                o_best.prio  = i_src[i].prio;
                o_best.idx   = i[dip_pkg::IDXW-1:0];
            end
        end
    end

endmodule

// >>> hw/dip_top.sv
// Top of the dual interrupt priority resolver with stop-mode wake-up.
module dip_top (
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_rst_n,
    input  dip_pkg::dip_src_t  [dip_pkg::NSRC-1:0] i_pri_src,
    input  dip_pkg::dip_src_t  [dip_pkg::NSRC-1:0] i_sec_src,
    input  wire logic                              i_lpc_wr,
    input  wire logic          [7:0]               i_lpc_data,
    input  wire logic                              i_stop_mode,
    input  wire logic                              i_swack_rd,
    output logic               [7:0]               o_lpc,
    output logic                                   o_wake,
    output logic                                   o_ack_valid,
    output logic               [7:0]               o_ack_vector,
    output logic               [5:0]               o_ack_lvlpri
);

    // Rank compare of two requests by level first and priority second.
    function automatic logic ranks_above(input dip_pkg::dip_best_t a, input dip_pkg::dip_best_t b);
        ranks_above = a.valid && (!b.valid || ({a.level, a.prio} > {b.level, b.prio}));
    endfunction

    // Low-power interrupt control register and its next value.
    logic [7:0] lpc_q;
    logic [7:0] lpc_d;
    // Acknowledge answer registers.
    logic       ack_valid_q;
    logic       ack_valid_d;
    logic [7:0] ack_vec_q;
    logic [7:0] ack_vec_d;
    logic [5:0] ack_lp_q;
    logic [5:0] ack_lp_d;

    // Clamped mask, wake enable and the controllers' outputs.
    logic [2:0]         mask_raw;
    logic [2:0]         mask_eff;
    logic               wake_en;
    dip_pkg::dip_best_t pri_best;
    dip_pkg::dip_best_t sec_best;
    logic               pri_wake;
    logic               sec_wake;
    logic               sec_wins;

    // Mask field as written by software.
    assign mask_raw = lpc_q[dip_pkg::LPC_MASK_HI:dip_pkg::LPC_MASK_LO];
    // A mask of seven is pulled down to six so a top-level request still wakes.
    assign mask_eff = (mask_raw > dip_pkg::MASK_CEIL) ? dip_pkg::MASK_CEIL : mask_raw;
    // Evaluation runs only when enabled by software and the core is stopped.
    assign wake_en  = lpc_q[dip_pkg::LPC_EN_BIT] && i_stop_mode;

    // Primary controller evaluator.
    dip_ctrl_eval u_pri (
        .i_src     (i_pri_src),
        .i_mask    (mask_eff),
        .i_wake_en (wake_en),
        .o_best    (pri_best),
        .o_wake    (pri_wake)
    );

    // Secondary controller evaluator.
    dip_ctrl_eval u_sec (
        .i_src     (i_sec_src),
        .i_mask    (mask_eff),
        .i_wake_en (wake_en),
        .o_best    (sec_best),
        .o_wake    (sec_wake)
    );

    // Either controller alone wakes the clock generator; no flop on this path.
    assign o_wake = pri_wake || sec_wake;

    // Secondary is chosen only when it strictly outranks the primary's best.
    assign sec_wins = ranks_above(sec_best, pri_best);

    // Next value of the low-power control register.
    always_comb begin
        // The byte is held unless software writes it.
        lpc_d = lpc_q;
        // Software write loads the whole byte.
        if (i_lpc_wr) begin
            lpc_d = i_lpc_data;
        end
    end

    // Next value of the acknowledge answer.
    always_comb begin
        // The strobe follows the read; vector and level-priority hold otherwise.
        ack_valid_d = i_swack_rd;
        ack_vec_d   = ack_vec_q;
        ack_lp_d    = ack_lp_q;
        if (i_swack_rd) begin
            // Winner across both controllers goes out with its level and priority.
            if (sec_wins) begin
                // Secondary strictly outranks the primary's best.
                ack_vec_d = dip_pkg::SEC_VEC_BASE + {5'h00, sec_best.idx};
                ack_lp_d  = {sec_best.level, sec_best.prio};
            end else if (pri_best.valid) begin
                // Primary best wins, ties included.
                ack_vec_d = dip_pkg::PRI_VEC_BASE + {5'h00, pri_best.idx};
                ack_lp_d  = {pri_best.level, pri_best.prio};
            end else begin
                // Nothing pending: zero vector and cleared level-priority.
                ack_vec_d = dip_pkg::VEC_NONE;
                ack_lp_d  = dip_pkg::LP_NONE;
            end
        end
    end

    // Register stage for all state.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            // Synchronous reset clears the register and the answer.
            lpc_q       <= dip_pkg::LPC_RESET;
            ack_valid_q <= 1'b0;
            ack_vec_q   <= dip_pkg::VEC_NONE;
            ack_lp_q    <= dip_pkg::LP_NONE;
        end else begin
            // Every register takes its next value on every edge.
            lpc_q       <= lpc_d;
            ack_valid_q <= ack_valid_d;
            ack_vec_q   <= ack_vec_d;
            ack_lp_q    <= ack_lp_d;
        end
    end

    // Outputs come straight from the registers.
    assign o_lpc        = lpc_q;
    assign o_ack_valid  = ack_valid_q;
    assign o_ack_vector = ack_vec_q;
    assign o_ack_lvlpri = ack_lp_q;

    // A write lands in the register on the next edge.
    a_lpc_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_lpc_wr |=> (o_lpc == $past(i_lpc_data)))
        else $error("Low-power control register did not take the written byte.");

    // Without the stop wake enable bit there is never a wake-up.
    a_wake_enable_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_lpc[dip_pkg::LPC_EN_BIT] |-> !o_wake)
        else $error("Wake-up asserted with stop wake enable clear.");

    // The wake path is idle while the core runs.
    a_wake_only_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_stop_mode |-> !o_wake)
        else $error("Wake-up asserted outside stop mode.");

    // A level seven primary request wakes whatever mask was written.
    a_top_level_wakes: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wake_en && pri_best.valid && pri_best.level == dip_pkg::LEVEL_TOP) |-> o_wake)
        else $error("Level seven request failed to wake.");

    // A secondary request above the mask wakes in the same cycle.
    a_sec_wake_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wake_en && sec_best.valid && sec_best.level > mask_eff) |-> o_wake)
        else $error("Secondary request above mask did not wake.");

    // No wake-up while every active request sits at or below the mask.
    a_no_wake_below: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ((!pri_best.valid || pri_best.level <= mask_eff) && (!sec_best.valid || sec_best.level <= mask_eff))
        |-> !o_wake)
        else $error("Wake-up asserted with no request above the mask.");

    // On equal rank the primary's vector is returned.
    a_tie_primary: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_swack_rd && pri_best.valid && sec_best.valid &&
         {pri_best.level, pri_best.prio} == {sec_best.level, sec_best.prio})
        |=> (o_ack_valid && o_ack_vector == dip_pkg::PRI_VEC_BASE + {5'h00, $past(pri_best.idx)}))
        else $error("Tie not resolved toward the primary controller.");

    // A strictly higher secondary request is returned with its rank.
    a_sec_outranks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_swack_rd && sec_best.valid && (!pri_best.valid ||
         {sec_best.level, sec_best.prio} > {pri_best.level, pri_best.prio}))
        |=> (o_ack_vector == dip_pkg::SEC_VEC_BASE + {5'h00, $past(sec_best.idx)} &&
             o_ack_lvlpri == {$past(sec_best.level), $past(sec_best.prio)}))
        else $error("Higher secondary request was not returned.");

    // An empty read answers zero and clears level-priority.
    a_empty_ack: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_swack_rd && !pri_best.valid && !sec_best.valid)
        |=> (o_ack_vector == dip_pkg::VEC_NONE && o_ack_lvlpri == dip_pkg::LP_NONE))
        else $error("Empty acknowledge did not return zero.");

    // Answer holds steady between reads.
    a_ack_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_swack_rd |=> (!o_ack_valid && $stable(o_ack_vector) && $stable(o_ack_lvlpri)))
        else $error("Acknowledge answer changed without a read.");

    // Every read is answered by a one-cycle strobe on the next edge.
    a_ack_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_swack_rd |=> o_ack_valid)
        else $error("Soft acknowledge read got no answer strobe.");

    // A primary request above the mask wakes in the same cycle.
    a_pri_wake_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wake_en && pri_best.valid && pri_best.level > mask_eff) |-> o_wake)
        else $error("Primary request above mask did not wake.");

    // A primary best at or above the secondary's rank is returned with its rank.
    a_pri_outranks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_swack_rd && pri_best.valid && (!sec_best.valid ||
         {pri_best.level, pri_best.prio} >= {sec_best.level, sec_best.prio}))
        |=> (o_ack_vector == dip_pkg::PRI_VEC_BASE + {5'h00, $past(pri_best.idx)} &&
             o_ack_lvlpri == {$past(pri_best.level), $past(pri_best.prio)}))
        else $error("Primary request of equal or higher rank was not returned.");

    // The control register keeps its byte between writes.
    a_lpc_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_lpc_wr |=> $stable(o_lpc))
        else $error("Low-power control register changed without a write.");

    // A level seven secondary request wakes whatever mask was written.
    a_sec_top_wakes: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (wake_en && sec_best.valid && sec_best.level == dip_pkg::LEVEL_TOP) |-> o_wake)
        else $error("Level seven secondary request failed to wake.");

    // A programmed mask of seven is compared as six.
    a_mask_clamp: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mask_raw == dip_pkg::LEVEL_TOP) |-> (mask_eff == dip_pkg::MASK_CEIL))
        else $error("Mask of seven was not clamped to six.");

    // A wake-up always has an enabled evaluation and a request above the mask behind it.
    a_wake_has_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_wake |-> (wake_en && ((pri_best.valid && pri_best.level > mask_eff) ||
                                (sec_best.valid && sec_best.level > mask_eff))))
        else $error("Wake-up asserted without an enabled request above the mask.");

endmodule

// >>> testbench/dip_core_model.sv
// Behavioural core and clock generator that enters stop mode and leaves it on wake-up.
module dip_core_model (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_stop_req,
    input  wire logic i_wake,
    output logic      o_stop_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic stop_d; // Next stop state.
    logic stop_q; // Core is stopped.
    // A wake-up seen while stopped restarts the clock trees, so stop drops for a cycle.
    always_comb begin
        stop_d = i_stop_req & ~(stop_q & i_wake);
    end
    // Register the stop state; the core runs after reset.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
        end
    end
    assign o_stop_mode = stop_q;
endmodule

// >>> testbench/dual_irq_priority_and_stop_wakeup_tb_top.sv
// Self-checking bench for the dual interrupt priority resolver and stop wake-up.
module dual_irq_priority_and_stop_wakeup_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SW = dip_pkg::NSRC * 7; // Width of a source vector.
    logic                                  clk;       // Reference clock.
    logic                                  rst_n;     // Synchronous reset.
    dip_pkg::dip_src_t [dip_pkg::NSRC-1:0] pri_src;   // Primary sources.
    dip_pkg::dip_src_t [dip_pkg::NSRC-1:0] sec_src;   // Secondary sources.
    logic                                  wr;        // Register write strobe.
    logic [7:0]                            wdata;     // Register write data.
    logic                                  stop_req;  // Bench asks the core to stop.
    logic                                  stop_mode; // Core model stop state.
    logic                                  rd;        // Soft acknowledge read.
    logic [7:0]                            lpc;       // Register contents.
    logic                                  wake;      // Merged wake-up.
    logic                                  ack_valid; // Read answer strobe.
    logic [7:0]                            ack_vec;   // Read vector.
    logic [5:0]                            ack_lp;    // Read level and priority.
    int                                    bad_count;
    int                                    total_checks;
    dip_top dip_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_pri_src(pri_src), .i_sec_src(sec_src),
        .i_lpc_wr(wr), .i_lpc_data(wdata), .i_stop_mode(stop_mode), .i_swack_rd(rd),
        .o_lpc(lpc), .o_wake(wake), .o_ack_valid(ack_valid), .o_ack_vector(ack_vec),
        .o_ack_lvlpri(ack_lp));
    dip_core_model dip_core_model_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_stop_req(stop_req),
        .i_wake(wake), .o_stop_mode(stop_mode));
    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Compares a byte-wide result.
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Builds a source vector with one source set at the given index.
    function automatic logic [SW-1:0] one_src(input int idx, input logic act, input logic [2:0] lvl,
                                              input logic [2:0] pr);
        logic [SW-1:0] v;
        v = '0;
        v[idx*7 +: 7] = {act, lvl, pr};
        return v;
    endfunction
    // Writes the low-power control register with a one-cycle strobe.
    task automatic write_reg(input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        #1 chk_byte("lpc_reg", d, lpc);
    endtask
    // Presents sources, reads the soft acknowledge and checks the answer and its one-cycle strobe.
    task automatic ack_case(input int pi, input logic pa, input logic [5:0] plp, input int si, input logic sa,
                            input logic [5:0] slp, input logic [7:0] ev, input logic [5:0] elp);
        @(posedge clk);
        pri_src <= one_src(pi, pa, plp[5:3], plp[2:0]);
        sec_src <= one_src(si, sa, slp[5:3], slp[2:0]);
        rd      <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_byte("ack_valid", 8'h01, {7'h00, ack_valid});
        chk_byte("ack_vector", ev, ack_vec);
        chk_byte("ack_lvlpri", {2'h0, elp}, {2'h0, ack_lp});
        @(posedge clk);
        #1 chk_byte("ack_valid_drop", 8'h00, {7'h00, ack_valid});
    endtask
    // Ranking across the two controllers, then a read that finds nothing pending.
    task automatic test_ranking();
        ack_case(2, 1'b1, 6'h1c, 5, 1'b1, 6'h1c, 8'h42, 6'h1c);
        ack_case(1, 1'b1, 6'h17, 6, 1'b1, 6'h28, 8'h86, 6'h28);
        ack_case(0, 1'b1, 6'h22, 3, 1'b1, 6'h23, 8'h83, 6'h23);
        ack_case(7, 1'b1, 6'h31, 0, 1'b1, 6'h2f, 8'h47, 6'h31);
        ack_case(0, 1'b0, 6'h3f, 4, 1'b1, 6'h09, 8'h84, 6'h09);
        ack_case(0, 1'b0, 6'h3f, 0, 1'b0, 6'h3f, 8'h00, 6'h00);
    endtask
    // Programs the register, settles the stop state, then raises one source and checks the wake line
    // in that same cycle, before the core model restarts and drops stop mode.
    task automatic wake_case(input logic en, input logic [2:0] m, input logic stp, input logic sec,
                             input logic [2:0] lvl, input logic exp);
        write_reg({en, m, 4'h5});
        @(posedge clk);
        stop_req <= stp;
        pri_src  <= '0;
        sec_src  <= '0;
        repeat (2) @(posedge clk);
        pri_src <= one_src(3, !sec, lvl, 3'h2);
        sec_src <= one_src(6, sec, lvl, 3'h2);
        #1 chk_byte("wake", {7'h00, exp}, {7'h00, wake});
    endtask
    // Every mask against every level, with the clamp, plus the gating conditions.
    task automatic test_wake();
        for (int m = 0; m < 8; m++) begin
            for (int l = 0; l < 8; l++) begin
                wake_case(1'b1, m[2:0], 1'b1, 1'b0, l[2:0], l > ((m > 6) ? 6 : m));
            end
        end
        wake_case(1'b0, 3'h0, 1'b1, 1'b0, 3'h7, 1'b0);
        wake_case(1'b1, 3'h0, 1'b0, 1'b0, 3'h7, 1'b0);
        wake_case(1'b1, 3'h7, 1'b1, 1'b1, 3'h7, 1'b1);
        wake_case(1'b1, 3'h2, 1'b1, 1'b1, 3'h5, 1'b1);
        @(posedge clk);
        #1 chk_byte("wake_after_restart", 8'h00, {7'h00, wake});
    endtask
    // Main sequence: reset, reset values, then the scenarios.
    initial begin
        bad_count = 0;
        total_checks = 0;
        rst_n = 1'b0;
        pri_src = '0;
        sec_src = '0;
        wr = 1'b0;
        wdata = 8'h00;
        stop_req = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk_byte("lpc_reset", dip_pkg::LPC_RESET, lpc);
        chk_byte("vector_reset", 8'h00, ack_vec);
        chk_byte("lvlpri_reset", 8'h00, {2'h0, ack_lp});
        chk_byte("ack_valid_reset", 8'h00, {7'h00, ack_valid});
        chk_byte("wake_reset", 8'h00, {7'h00, wake});
        write_reg(8'hd5);
        test_ranking();
        test_wake();
        wrap_up();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule
